/* File: src/reset_sources_and_watchdog.sv */
// Functional notes
// - A long enough low on the reset pin resets the core, even with no clock.
// - After the pin returns high, release the core only after the start-up time-out.
// - With brown-out fuse set, supply-low resets three clocks later via the synchroniser; release after time-out.
// - A watchdog time-out makes an internal reset pulse of exactly one clock.
// - Start-up counting begins when that pulse ends; core stays in reset meanwhile.
// - Status bit 4 marks a scan-chain reset; cleared by power-on or writing zero.
// - Status bit 3 marks a watchdog reset; cleared by power-on or writing zero.
// - Status bit 2 marks a brown-out reset; cleared by power-on or writing zero.
// - Status bit 1 marks a pin reset; cleared by power-on or writing zero.
// - Status bit 0 set by power-on; only a software zero write clears it.
// - In legacy mode only the pin and power-on flags exist.
// - The watchdog counts ticks of its own oscillator, nominally 1 MHz.
// - Watchdog count restarts on restart instruction, on disable and on chip reset.
// - An elapsed watchdog period without restart resets the device.
// - Safety level from two fuses; level 2 starts enabled, levels 0 and 1 disabled.
// - Writing one to the enable bit always enables, with no sequence.
// - Levels 1 and 2 take prescaler writes only with change-enable set.
// - Hardware clears change-enable four clocks after software sets it.
// - A zero write to enable is ignored unless change-enable reads one.
// - In level 2 the watchdog cannot be disabled.
// - Prescaler field selects 16384 oscillator cycles shifted left by its value.
// - Control register bits 7 to 5 always read zero.
// - The core stays in reset while the scan-chain reset bit is one.
// - Power-on detection reasserts reset at once.
`timescale 1ns/1ps
`default_nettype none
module reset_sources_and_watchdog #(
  parameter int STARTUP_CYCLES = rst_wdt_pkg::STARTUP_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ext_resetn,
  input  wire logic        supply_low,
  input  wire logic        scan_core_reset_instruction,
  input  wire logic        watchdog_osc,
  input  wire logic        brownout_enable_fuse,
  input  wire logic        legacy_compat_fuse,
  input  wire logic        watchdog_always_on_fuse,
  input  wire logic        watchdog_restart,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             core_resetn,
  output logic             watchdog_reset_pulse
);

  localparam logic [rst_wdt_pkg::STARTUP_CNT_W-1:0] STARTUP_LAST =
    rst_wdt_pkg::STARTUP_CNT_W'(STARTUP_CYCLES - 1);
  localparam logic [rst_wdt_pkg::WDT_CNT_W-1:0] WDT_BASE =
    rst_wdt_pkg::WDT_CNT_W'(rst_wdt_pkg::WDT_BASE_CYCLES);

  // Synchronised pin inputs.
  sync_if #(.WIDTH(rst_wdt_pkg::SYNC_W)) pins ();

  logic pin_req;
  logic supply_low_s;
  logic scan_req;
  logic osc_s;
  logic bod_fuse;
  logic compat_fuse;
  logic always_fuse;

  assign pins.async_in[rst_wdt_pkg::SYNC_PIN_REQ]     = ~ext_resetn;
  assign pins.async_in[rst_wdt_pkg::SYNC_SUPPLY_LOW]  = supply_low;
  assign pins.async_in[rst_wdt_pkg::SYNC_SCAN_REQ]    = scan_core_reset_instruction;
  assign pins.async_in[rst_wdt_pkg::SYNC_WDT_OSC]     = watchdog_osc;
  assign pins.async_in[rst_wdt_pkg::SYNC_BOD_FUSE]    = brownout_enable_fuse;
  assign pins.async_in[rst_wdt_pkg::SYNC_COMPAT_FUSE] = legacy_compat_fuse;
  assign pins.async_in[rst_wdt_pkg::SYNC_ALWAYS_FUSE] = watchdog_always_on_fuse;

  pin_sync #(.WIDTH(rst_wdt_pkg::SYNC_W)) u_pin_sync (
    .clk    (clk),
    .resetn (resetn),
    .lanes  (pins)
  );

  assign pin_req      = pins.sync_out[rst_wdt_pkg::SYNC_PIN_REQ];
  assign supply_low_s = pins.sync_out[rst_wdt_pkg::SYNC_SUPPLY_LOW];
  assign scan_req     = pins.sync_out[rst_wdt_pkg::SYNC_SCAN_REQ];
  assign osc_s        = pins.sync_out[rst_wdt_pkg::SYNC_WDT_OSC];
  assign bod_fuse     = pins.sync_out[rst_wdt_pkg::SYNC_BOD_FUSE];
  assign compat_fuse  = pins.sync_out[rst_wdt_pkg::SYNC_COMPAT_FUSE];
  assign always_fuse  = pins.sync_out[rst_wdt_pkg::SYNC_ALWAYS_FUSE];

  // Safety level from the fuses.
  rst_wdt_pkg::safety_level_t level;

  always_comb begin
    if (always_fuse) begin
      level = rst_wdt_pkg::LEVEL2;
    end else if (compat_fuse) begin
      level = rst_wdt_pkg::LEVEL0;
    end else begin
      level = rst_wdt_pkg::LEVEL1;
    end
  end

  // Reset requests.
  logic bod_req;
  logic hold_req;

  assign bod_req  = bod_fuse & supply_low_s;
  assign hold_req = pin_req | bod_req | scan_req | watchdog_reset_pulse;

  // Start-up sequencer. The pin and power-on resets act without the clock.
  rst_wdt_pkg::seq_state_t              state;
  logic [rst_wdt_pkg::STARTUP_CNT_W-1:0] startup_cnt;

  always_ff @(posedge clk or negedge resetn or negedge ext_resetn) begin
    if (!resetn || !ext_resetn) begin
      state       <= rst_wdt_pkg::ST_HOLD;
      startup_cnt <= '0;
      core_resetn <= 1'b0;
    end else begin
      case (state)
        rst_wdt_pkg::ST_HOLD: begin
          core_resetn <= 1'b0;
          startup_cnt <= '0;
          if (!hold_req) begin
            state <= rst_wdt_pkg::ST_COUNT;
          end
        end
        rst_wdt_pkg::ST_COUNT: begin
          if (hold_req) begin
            state       <= rst_wdt_pkg::ST_HOLD;
            startup_cnt <= '0;
          end else if (startup_cnt == STARTUP_LAST) begin
            state       <= rst_wdt_pkg::ST_RUN;
            core_resetn <= 1'b1;
          end else begin
            startup_cnt <= startup_cnt + 1'b1;
          end
        end
        rst_wdt_pkg::ST_RUN: begin
          if (hold_req) begin
            state       <= rst_wdt_pkg::ST_HOLD;
            core_resetn <= 1'b0;
          end
        end
        default: begin
          state       <= rst_wdt_pkg::ST_HOLD;
          startup_cnt <= '0;
          core_resetn <= 1'b0;
        end
      endcase
    end
  end

  // APB decode.
  logic setup_phase;
  logic access_done;
  logic addr_cause;
  logic addr_control;
  logic write_cause;
  logic write_control;

  assign setup_phase   = psel & ~penable;
  assign access_done   = psel & penable & pready;
  assign addr_cause    = (paddr == rst_wdt_pkg::ADDR_RESET_CAUSE);
  assign addr_control  = (paddr == rst_wdt_pkg::ADDR_WDT_CONTROL);
  assign write_cause   = access_done & pwrite & addr_cause;
  assign write_control = access_done & pwrite & addr_control;

  // Watchdog control fields.
  logic                               watchdog_change_enable;
  logic                               watchdog_enable_bit;
  logic [rst_wdt_pkg::PRESCALE_W-1:0] watchdog_prescale;
  logic [1:0]                         change_cnt;
  logic                               wr_change;
  logic                               wr_enable;
  logic [rst_wdt_pkg::PRESCALE_W-1:0] wr_prescale;
  logic                               wdt_active;

  assign wr_change   = pwdata[rst_wdt_pkg::CHANGE_ENABLE_BIT];
  assign wr_enable   = pwdata[rst_wdt_pkg::ENABLE_BIT];
  assign wr_prescale = pwdata[rst_wdt_pkg::PRESCALE_LSB +: rst_wdt_pkg::PRESCALE_W];
  assign wdt_active  = watchdog_enable_bit | (level == rst_wdt_pkg::LEVEL2);

  // Change-enable opens only with a write of ones to both bits.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      watchdog_change_enable <= 1'b0;
      change_cnt             <= '0;
    end else if (write_control && wr_change && wr_enable) begin
      watchdog_change_enable <= 1'b1;
      change_cnt             <= '0;
    end else if (watchdog_change_enable) begin
      if (change_cnt == rst_wdt_pkg::CHANGE_WINDOW_LAST) begin
        watchdog_change_enable <= 1'b0;
        change_cnt             <= '0;
      end else begin
        change_cnt <= change_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      watchdog_enable_bit <= 1'b0;
    end else if (write_control) begin
      if (wr_enable) begin
        watchdog_enable_bit <= 1'b1;
      end else if (watchdog_change_enable) begin
        watchdog_enable_bit <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      watchdog_prescale <= rst_wdt_pkg::PRESCALE_RESET_VALUE;
    end else if (write_control &&
                 ((level == rst_wdt_pkg::LEVEL0) || watchdog_change_enable)) begin
      watchdog_prescale <= wr_prescale;
    end
  end

  // Watchdog counter on oscillator ticks.
  logic                              osc_prev;
  logic                              osc_tick;
  logic [rst_wdt_pkg::WDT_CNT_W-1:0] wdt_cnt;
  logic [rst_wdt_pkg::WDT_CNT_W-1:0] wdt_last;
  logic                              wdt_clear;

  assign osc_tick  = osc_s & ~osc_prev;
  assign wdt_last  = (WDT_BASE << watchdog_prescale) - 1'b1;
  assign wdt_clear = watchdog_restart | ~wdt_active | ~core_resetn;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      osc_prev <= 1'b0;
    end else begin
      osc_prev <= osc_s;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wdt_cnt              <= '0;
      watchdog_reset_pulse <= 1'b0;
    end else begin
      watchdog_reset_pulse <= 1'b0;
      if (wdt_clear) begin
        wdt_cnt <= '0;
      end else if (osc_tick) begin
        if (wdt_cnt == wdt_last) begin
          wdt_cnt              <= '0;
          watchdog_reset_pulse <= 1'b1;
        end else begin
          wdt_cnt <= wdt_cnt + 1'b1;
        end
      end
    end
  end

  // Reset-cause flags; a set in the same cycle as a clear wins.
  logic [4:0] cause;
  logic [4:0] cause_set;
  logic [4:0] cause_clr;

  always_comb begin
    cause_set = '0;
    cause_set[rst_wdt_pkg::PIN_FLAG_BIT] = pin_req;
    if (!compat_fuse) begin
      cause_set[rst_wdt_pkg::SCAN_FLAG_BIT]     = scan_req;
      cause_set[rst_wdt_pkg::WDT_FLAG_BIT]      = watchdog_reset_pulse;
      cause_set[rst_wdt_pkg::BROWNOUT_FLAG_BIT] = bod_req;
    end
    cause_clr = write_cause ? ~pwdata[4:0] : 5'h00;
  end

  // Power-on reset sets bit 0 and clears the others.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cause <= rst_wdt_pkg::CAUSE_RESET_VALUE;
    end else begin
      cause <= (cause & ~cause_clr) | cause_set;
    end
  end

  // Read data views.
  logic [7:0] cause_view;
  logic [7:0] control_view;

  always_comb begin
    cause_view = {3'h0, cause};
    if (compat_fuse) begin
      cause_view[rst_wdt_pkg::SCAN_FLAG_BIT]     = 1'b0;
      cause_view[rst_wdt_pkg::WDT_FLAG_BIT]      = 1'b0;
      cause_view[rst_wdt_pkg::BROWNOUT_FLAG_BIT] = 1'b0;
    end
    control_view = 8'h00;
    control_view[rst_wdt_pkg::CHANGE_ENABLE_BIT] = watchdog_change_enable;
    control_view[rst_wdt_pkg::ENABLE_BIT]        = wdt_active;
    control_view[rst_wdt_pkg::PRESCALE_LSB +: rst_wdt_pkg::PRESCALE_W] = watchdog_prescale;
  end

  // APB answer: one wait-free access phase, registered outputs.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase & ~(addr_cause | addr_control);
      if (setup_phase && !pwrite && addr_cause) begin
        prdata <= {24'h00_0000, cause_view};
      end else if (setup_phase && !pwrite && addr_control) begin
        prdata <= {24'h00_0000, control_view};
      end else if (setup_phase) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule : reset_sources_and_watchdog
`default_nettype wire

/* File: pkg/rst_wdt_pkg.sv */
package rst_wdt_pkg;

  // APB register byte addresses.
  localparam logic [7:0] ADDR_RESET_CAUSE   = 8'h00;
  localparam logic [7:0] ADDR_WDT_CONTROL   = 8'h04;

  // Field positions of the reset-cause status register.
  localparam int SCAN_FLAG_BIT     = 4;
  localparam int WDT_FLAG_BIT      = 3;
  localparam int BROWNOUT_FLAG_BIT = 2;
  localparam int PIN_FLAG_BIT      = 1;
  localparam int POWER_ON_FLAG_BIT = 0;

  // Field positions of the watchdog control register.
  localparam int CHANGE_ENABLE_BIT = 4;
  localparam int ENABLE_BIT        = 3;
  localparam int PRESCALE_LSB      = 0;
  localparam int PRESCALE_W        = 3;

  // Reset values.
  localparam logic [4:0] CAUSE_RESET_VALUE    = 5'h01;
  localparam logic [2:0] PRESCALE_RESET_VALUE = 3'h0;

  // Change-enable window length in system clock cycles.
  localparam int          CHANGE_WINDOW_CYCLES = 4;
  localparam logic [1:0]  CHANGE_WINDOW_LAST   = 2'(CHANGE_WINDOW_CYCLES - 1);

  // Watchdog time-out base in oscillator cycles; the prescaler shifts it left.
  localparam int WDT_BASE_CYCLES = 16384;
  localparam int WDT_CNT_W       = 22;

  // Start-up time-out.
  localparam int CLK_PERIOD_NS      = 50;
  localparam int STARTUP_TIMEOUT_US = 4100;
  localparam int STARTUP_CYCLES     = (STARTUP_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_CNT_W      = 20;

  // Synchroniser lanes for pin inputs.
  localparam int SYNC_W           = 7;
  localparam int SYNC_PIN_REQ     = 0;
  localparam int SYNC_SUPPLY_LOW  = 1;
  localparam int SYNC_SCAN_REQ    = 2;
  localparam int SYNC_WDT_OSC     = 3;
  localparam int SYNC_BOD_FUSE    = 4;
  localparam int SYNC_COMPAT_FUSE = 5;
  localparam int SYNC_ALWAYS_FUSE = 6;

  typedef enum logic [2:0] {
    LEVEL0 = 3'b001,
    LEVEL1 = 3'b010,
    LEVEL2 = 3'b100
  } safety_level_t;

  typedef enum logic [2:0] {
    ST_HOLD  = 3'b001,
    ST_COUNT = 3'b010,
    ST_RUN   = 3'b100
  } seq_state_t;

endpackage : rst_wdt_pkg

/* File: pkg/sync_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sync_if #(parameter int WIDTH = 1);
  logic [WIDTH-1:0] async_in;
  logic [WIDTH-1:0] sync_out;
  modport syncer (input async_in, output sync_out);
  modport user   (output async_in, input sync_out);
endinterface : sync_if
`default_nettype wire

/* File: src/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic clk,
  input  wire logic resetn,
  sync_if.syncer    lanes
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  // Stage one feeds only stage two.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= lanes.async_in;
      stage2 <= stage1;
    end
  end

  assign lanes.sync_out = stage2;

endmodule : pin_sync
`default_nettype wire

/* File: verification/reset_sources_and_watchdog_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module reset_sources_and_watchdog_monitor #(
  parameter int STARTUP_CYCLES = 8
) (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        ext_resetn,
  input wire logic        supply_low,
  input wire logic        scan_core_reset_instruction,
  input wire logic        brownout_enable_fuse,
  input wire logic        legacy_compat_fuse,
  input wire logic        watchdog_always_on_fuse,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        core_resetn,
  input wire logic        watchdog_reset_pulse
);
  logic [19:0] quiet_cnt;
  logic        bod_req;
  logic        rd_done;
  assign bod_req = brownout_enable_fuse && supply_low;
  assign rd_done = psel && penable && pready && !pwrite;
  // Counts cycles free of any reset request, so an early core release shows up.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      quiet_cnt <= 20'h0_0000;
    end else if (!ext_resetn || scan_core_reset_instruction || bod_req || watchdog_reset_pulse) begin
      quiet_cnt <= 20'h0_0000;
    end else if (quiet_cnt != 20'hF_FFFF) begin
      quiet_cnt <= quiet_cnt + 20'h0_0001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_pulse_one_cycle: assert property (watchdog_reset_pulse |=> !watchdog_reset_pulse)
    else $error("watchdog reset pulse longer than one cycle");
  a_pulse_resets_core: assert property (watchdog_reset_pulse |=> !core_resetn)
    else $error("watchdog pulse did not reset the core");
  a_pin_async_reset: assert property (!ext_resetn |-> !core_resetn)
    else $error("core not in reset while pin is low");
  a_scan_holds_core: assert property (scan_core_reset_instruction [*5] |-> !core_resetn)
    else $error("core not held by scan reset");
  a_brownout_holds_core: assert property (bod_req [*5] |-> !core_resetn)
    else $error("core not held by brown-out");
  a_startup_delay: assert property ($rose(core_resetn) |-> quiet_cnt >= STARTUP_CYCLES)
    else $error("core released before start-up delay");
  a_apb_one_access: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not a single access cycle");
  a_unmapped_error: assert property (psel && !penable && paddr != rst_wdt_pkg::ADDR_RESET_CAUSE
    && paddr != rst_wdt_pkg::ADDR_WDT_CONTROL |=> pslverr)
    else $error("unmapped address without error");
  a_reserved_zero: assert property (rd_done |-> prdata[31:5] == 27'h000_0000)
    else $error("reserved read bits not zero");
  a_level2_enabled: assert property (watchdog_always_on_fuse [*5] ##0 (rd_done
    && paddr == rst_wdt_pkg::ADDR_WDT_CONTROL) |-> prdata[3])
    else $error("watchdog enable reads zero in level 2");
  a_legacy_flags: assert property (legacy_compat_fuse [*5] ##0 (rd_done
    && paddr == rst_wdt_pkg::ADDR_RESET_CAUSE) |-> prdata[4:2] == 3'h0)
    else $error("legacy mode shows extra flags");
  c_wdt_pulse: cover property (watchdog_reset_pulse);
  c_core_release: cover property ($rose(core_resetn));
  c_unmapped: cover property (pslverr);
endmodule : reset_sources_and_watchdog_monitor
`default_nettype wire

/* File: verification/test_reset_sources_and_watchdog.sv */
`timescale 1ns/1ps
`default_nettype none
module test_reset_sources_and_watchdog;
  localparam int         STARTUP = 8;
  localparam int         WD_CYC  = rst_wdt_pkg::WDT_BASE_CYCLES * 2;
  localparam logic [7:0] ST      = rst_wdt_pkg::ADDR_RESET_CAUSE;
  localparam logic [7:0] CT      = rst_wdt_pkg::ADDR_WDT_CONTROL;
  logic        clk = 0, resetn = 0, ext_resetn = 1, supply_low = 0, scan = 0, osc = 0, osc_on = 0;
  logic        bod_fuse = 0, compat = 0, always_on = 0, wdr = 0;
  logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, core_resetn, wd_pulse;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [32:0] expq[$];
  int          errors = 0, compares = 0, seed = 71473, pulses = 0, n;
  logic [2:0]  p;
  reset_sources_and_watchdog #(.STARTUP_CYCLES(STARTUP)) i_reset_sources_and_watchdog (
    .clk(clk), .resetn(resetn), .ext_resetn(ext_resetn), .supply_low(supply_low),
    .scan_core_reset_instruction(scan), .watchdog_osc(osc), .brownout_enable_fuse(bod_fuse),
    .legacy_compat_fuse(compat), .watchdog_always_on_fuse(always_on), .watchdog_restart(wdr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_resetn(core_resetn),
    .watchdog_reset_pulse(wd_pulse));
  always #25 clk = ~clk;
  // The watchdog oscillator runs at half the system clock to keep time-outs short.
  always @(posedge clk) osc <= osc_on & ~osc;
  always @(posedge clk) if (wd_pulse) pulses++;
  always @(posedge clk) if (psel && penable && pready && !pwrite) check({pslverr, prdata}, expq.pop_front());
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (!pready);
    psel <= 0; penable <= 0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(a, 0, 32'h0000_0000);
  endtask : rd
  task automatic wait_core;
    for (int k = 0; k < 100 && !core_resetn; k++) @(posedge clk);
    check(core_resetn, 1);
  endtask : wait_core
  task automatic complete_run;
    if (errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  initial begin
    repeat (95000) @(posedge clk);
    errors++;
    complete_run();
  end
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1;
    rd(ST, 33'h0_0000_0001);
    rd(CT, 33'h0_0000_0000);
    rd(8'h08, 33'h1_0000_0000);
    apb(8'h0C, 1, $random(seed));
    apb(ST, 1, 32'h0000_0000);
    rd(ST, 33'h0_0000_0000);
    wait_core();
    ext_resetn <= 0;
    repeat (4) @(posedge clk);
    check(core_resetn, 0);
    ext_resetn <= 1;
    repeat (STARTUP) @(posedge clk);
    check(core_resetn, 0);
    wait_core();
    rd(ST, 33'h0_0000_0002);
    supply_low <= 1;
    repeat (8) @(posedge clk);
    check(core_resetn, 1);
    bod_fuse <= 1;
    repeat (8) @(posedge clk);
    check(core_resetn, 0);
    supply_low <= 0;
    wait_core();
    rd(ST, 33'h0_0000_0006);
    compat <= 1;
    repeat (4) @(posedge clk);
    rd(ST, 33'h0_0000_0002);
    compat <= 0;
    apb(ST, 1, 32'h0000_0000);
    scan <= 1;
    repeat (20) @(posedge clk);
    check(core_resetn, 0);
    scan <= 0;
    wait_core();
    rd(ST, 33'h0_0000_0010);
    apb(ST, 1, 32'h0000_0000);
    apb(CT, 1, 32'h0000_00E8);
    rd(CT, 33'h0_0000_0008);
    apb(CT, 1, 32'h0000_0000);
    rd(CT, 33'h0_0000_0008);
    apb(CT, 1, 32'h0000_001F);
    rd(CT, 33'h0_0000_0018);
    repeat (3) @(posedge clk);
    rd(CT, 33'h0_0000_0008);
    apb(CT, 1, 32'h0000_0018);
    apb(CT, 1, 32'h0000_000D);
    rd(CT, 33'h0_0000_000D);
    apb(CT, 1, 32'h0000_000A);
    rd(CT, 33'h0_0000_000D);
    apb(CT, 1, 32'h0000_0018);
    repeat (2) @(posedge clk);
    apb(CT, 1, 32'h0000_0000);
    rd(CT, 33'h0_0000_000D);
    apb(CT, 1, 32'h0000_0018);
    apb(CT, 1, 32'h0000_0000);
    rd(CT, 33'h0_0000_0000);
    compat <= 1;
    repeat (4) @(posedge clk);
    p = 3'($random(seed));
    apb(CT, 1, {29'h0000_0000, p});
    rd(CT, {30'h0000_0000, p});
    compat <= 0;
    always_on <= 1;
    repeat (4) @(posedge clk);
    apb(CT, 1, 32'h0000_0018);
    apb(CT, 1, 32'h0000_0000);
    rd(CT, 33'h0_0000_0008);
    always_on <= 0;
    apb(CT, 1, 32'h0000_0018);
    apb(CT, 1, 32'h0000_0008);
    osc_on <= 1;
    repeat (3) begin
      repeat (12000) @(posedge clk);
      wdr <= 1;
      @(posedge clk);
      wdr <= 0;
    end
    check(pulses, 0);
    for (n = 0; n < 40000 && !wd_pulse; n++) @(posedge clk);
    check(n >= WD_CYC - 8 && n <= WD_CYC + 24, 1);
    @(posedge clk);
    check(core_resetn, 0);
    wait_core();
    check(pulses, 1);
    rd(ST, 33'h0_0000_0008);
    resetn <= 0;
    @(posedge clk);
    check(core_resetn, 0);
    resetn <= 1;
    rd(ST, 33'h0_0000_0001);
    @(posedge clk);
    check(expq.size(), 0);
    complete_run();
  end
endmodule : test_reset_sources_and_watchdog
bind reset_sources_and_watchdog reset_sources_and_watchdog_monitor #(.STARTUP_CYCLES(STARTUP_CYCLES))
  i_reset_sources_and_watchdog_monitor (.clk, .resetn, .ext_resetn, .supply_low, .scan_core_reset_instruction,
  .brownout_enable_fuse, .legacy_compat_fuse, .watchdog_always_on_fuse, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .core_resetn, .watchdog_reset_pulse);
`default_nettype wire
